/* File: design/wfe_regs.svh */
/*
  Register offsets, field positions, reset values and timing constants of the
  waveform output timing engine. Assumes inclusion by bare name.
*/
`ifndef WFE_REGS_SVH
`define WFE_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WFE_A_CTRL 8'h00
`define WFE_A_MODE 8'h04
`define WFE_A_PINS 8'h08
`define WFE_A_DIV 8'h0C
`define WFE_A_DLY 8'h10
`define WFE_A_CNT 8'h14
`define WFE_A_DATA 8'h18
`define WFE_A_STAT 8'h1C
`define WFE_A_DONE 8'h20

// ----------------------------------------
// Command bits
// ----------------------------------------
`define WFE_C_START 0
`define WFE_C_STOP 1
`define WFE_C_SWUPD 2
`define WFE_C_ECLR 3
`define WFE_C_STRIG 4

// ----------------------------------------
// Mode and pin select fields
// ----------------------------------------
`define WFE_M_TIM 1:0
`define WFE_M_RGN 3:2
`define WFE_M_EXT 4
`define WFE_M_SFALL 5
`define WFE_M_CTR 6
`define WFE_M_TB 8:7
`define WFE_M_SSRC 10:9
`define WFE_M_TFALL 11
`define WFE_M_PEN 12
`define WFE_M_PLOW 13
`define WFE_P_STRT 2:0
`define WFE_P_PAUS 5:3
`define WFE_P_SCLK 8:6
`define WFE_P_TB 11:9
`define WFE_P_XST 14:12
`define WFE_P_XSTE 15
`define WFE_P_XSC 18:16
`define WFE_P_XSCE 19

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WFE_R_MODE 14'h0000
`define WFE_R_PINS 20'h00000
`define WFE_R_DIV 24'h000014
`define WFE_R_DLY 16'h0002
`define WFE_R_CNT 32'h00000000

// ----------------------------------------
// Timing and sizes
// ----------------------------------------
`define WFE_CLK_HZ 26'h17D7840
`define WFE_TB_FAST_HZ 26'h1312D00
`define WFE_TB_SLOW_HZ 26'h00186A0
`define WFE_DEPTH 7'h40

`endif

/* File: design/wfe_pkg.sv */
/*
  Types of the waveform output timing engine: state, mode encodings, state
  records. Assumes nothing of its surroundings.
*/
package wfe_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ARM = 2'b01, ST_DLY = 2'b10, ST_RUN = 2'b11} wfe_state_t;
  typedef enum logic [1:0] {TIM_SW = 2'b00, TIM_FIN = 2'b01, TIM_CONT = 2'b10} wfe_tim_t;
  typedef enum logic [1:0] {RGN_STD = 2'b00, RGN_FIFO = 2'b01, RGN_NONE = 2'b10} wfe_rgn_t;
  typedef enum logic [1:0] {SS_CMD = 2'b00, SS_SWP = 2'b01, SS_PIN = 2'b10, SS_AIST = 2'b11} wfe_ssrc_t;
  typedef enum logic [1:0] {TB_FAST = 2'b00, TB_SLOW = 2'b01, TB_PIN = 2'b10} wfe_tb_t;

  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
  } wfe_sync_t;

  typedef struct packed {
    wfe_state_t st;
    logic aw_ok;
    logic w_ok;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [13:0] mode;
    logic [19:0] pins;
    logic [23:0] div;
    logic [15:0] dly;
    logic [31:0] cnt;
    logic [31:0] done;
    logic pend;
    logic [31:0] pend_d;
    logic [5:0] rd;
    logic [5:0] wr;
    logic [6:0] lvl;
    logic err;
    logic refused;
    logic [24:0] af;
    logic [24:0] as;
    logic [23:0] tbc;
    logic [15:0] pp;
    logic pist;
    logic pctr;
    logic [15:0] dac0;
    logic [15:0] dac1;
    logic upd;
    logic [15:0] fpo;
    logic [15:0] fpoe;
  } wfe_st_t;
endpackage

/* File: design/wfe_sync_if.sv */
/*
  Carrier of synchronised pin levels from the pin synchroniser to the engine.
  Assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface wfe_sync_if;
  logic [15:0] pin;
  logic ist;
  modport src (output pin, output ist);
  modport dst (input pin, input ist);
endinterface

/* File: design/wfe_pin_sync.sv */
/*
  Two-flop synchroniser for the function pins and the input start trigger.
  Assumes asynchronous pin inputs and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module wfe_pin_sync (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] fpin_i,
  input wire logic in_start_i,
  wfe_sync_if.src sync
);
  import wfe_pkg::*;

  wfe_sync_t q;
  wfe_sync_t n;

  // ----------------------------------------
  // Two stages; only the second is read
  // ----------------------------------------
  always_comb begin
    n = q;
    n.s1 = {in_start_i, fpin_i};
    n.s2 = q.s1;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sync.pin = q.s2[15:0];
  assign sync.ist = q.s2[16];
endmodule

/* File: design/wfe_engine.sv */
/*
  Waveform output timing engine: sample queue, start/pause triggers, sample
  clock selection and division, two-channel converter update, AXI4-Lite slave.
  Assumes a 25 MHz clock, asynchronous pins, a same-clock counter output.
*/
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "wfe_regs.svh"

// Functional notes
// - Both converter channels update together on one common sample event.
// - Each sample event takes one queue sample and drives both converters.
// - Software-timed mode: one command gives exactly one converter update.
// - Hardware-timed mode: queued host samples go out one per clock event.
// - Finite mode halts once the programmed sample count has been output.
// - Continuous mode runs without count limit until a stop command or an underflow.
// - Standard regeneration replays queue contents; host may keep writing.
// - Queue regeneration replays loaded data; writes while running are refused.
// - Non-regeneration never replays; running dry reports an underflow error.
// - Start trigger begins generation; without trigger a start command does.
// - Start source: software pulse, input pins, input start trigger; edge selectable.
// - Start trigger exportable as active-high pulse on pins 4-7, 12-15.
// - Active pause suppresses all hardware-timed sample events.
// - Pause never aborts a sample in progress; acts from next sample.
// - External clock resumes on first edge after pause deasserts.
// - Pause source from input pins; active level high or low.
// - Sample clock internal or external; update on chosen edge.
// - Internal clock from timebase divider or general counter output.
// - External sample clock from pins 0-3 or 8-11.
// - Start runs the divider; it stops once finite generation completes.
// - Divider clock only: programmable delay from start, two ticks by default.
// - Timebase: 20 MHz, 100 kHz or an input pin.
// - Sample clock exportable active low on pins 4-7, 12-15.
module wfe_engine (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] fpin_i,
  input wire logic in_start_i,
  input wire logic ctr_out_i,
  output logic [15:0] fpin_o,
  output logic [15:0] fpin_oe_o,
  output logic [15:0] dac0_o,
  output logic [15:0] dac1_o,
  output logic dac_upd_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  import wfe_pkg::*;

  wfe_st_t q;
  wfe_st_t n;
  logic [31:0] mem [0:63];
  logic [31:0] rd_word;
  logic [31:0] cw;
  logic [31:0] mw;
  logic [31:0] mwd;
  logic [3:0] p;
  logic tbf, tbs, tb, tick, pause_act, stg, fire, ev, pop, rot, push, regen, wcommit, mwe;

  wfe_sync_if sif ();

  wfe_pin_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .fpin_i(fpin_i),
    .in_start_i(in_start_i),
    .sync(sif.src)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [25:0] tb_adv(input logic [24:0] acc, input logic [25:0] step);
    logic [25:0] s;
    s = {1'b0, acc} + step;
    tb_adv = (s >= `WFE_CLK_HZ) ? {1'b1, 25'(s - `WFE_CLK_HZ)} : {1'b0, s[24:0]};
  endfunction

  function automatic logic [3:0] pin_in(input logic [2:0] i);
    pin_in = {i[2], 1'b0, i[1:0]};
  endfunction

  function automatic logic [3:0] pin_out(input logic [2:0] i);
    pin_out = {i[2], 1'b1, i[1:0]};
  endfunction

  function automatic logic edge_of(input logic cur, input logic prv, input logic fall);
    edge_of = fall ? (prv & ~cur) : (cur & ~prv);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[b*8 +: 8] = w[b*8 +: 8];
      end
    end
  endfunction

  assign rd_word = mem[q.rd];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    n = q;
    mw = 32'h00000000;
    n.upd = 1'b0;
    n.pp = sif.pin;
    n.pist = sif.ist;
    n.pctr = ctr_out_i;
    // Timebases from fractional accumulators
    {tbf, n.af} = tb_adv(q.af, `WFE_TB_FAST_HZ);
    {tbs, n.as} = tb_adv(q.as, `WFE_TB_SLOW_HZ);
    p = pin_in(q.pins[`WFE_P_TB]);
    case (q.mode[`WFE_M_TB])
      TB_FAST: tb = tbf;
      TB_SLOW: tb = tbs;
      default: tb = edge_of(sif.pin[p], q.pp[p], 1'b0);
    endcase
    // Pause level
    p = pin_in(q.pins[`WFE_P_PAUS]);
    pause_act = q.mode[`WFE_M_PEN] & (sif.pin[p] ^ q.mode[`WFE_M_PLOW]);
    // Sample clock source
    tick = 1'b0;
    if (q.mode[`WFE_M_EXT]) begin
      p = pin_in(q.pins[`WFE_P_SCLK]);
      tick = edge_of(sif.pin[p], q.pp[p], q.mode[`WFE_M_SFALL]);
    end else if (q.mode[`WFE_M_CTR]) begin
      tick = edge_of(ctr_out_i, q.pctr, q.mode[`WFE_M_SFALL]);
    end else if (tb && (q.st == ST_RUN || q.st == ST_DLY)) begin
      // Divider runs only while started delay first
      if (q.tbc + 24'h000001 >= ((q.st == ST_DLY) ? {8'h00, q.dly} : q.div)) begin
        tick = 1'b1;
        n.tbc = 24'h000000;
      end else begin
        n.tbc = q.tbc + 24'h000001;
      end
    end
    if (q.st == ST_DLY && tick) begin
      n.st = ST_RUN;
    end
    // Register write commit
    wcommit = q.aw_ok & q.w_ok & ~q.bvalid & ~q.pend;
    cw = (wcommit && q.waddr == `WFE_A_CTRL) ? q.wdata : 32'h00000000;
    // Start trigger source and edge
    p = pin_in(q.pins[`WFE_P_STRT]);
    case (q.mode[`WFE_M_SSRC])
      SS_SWP: stg = cw[`WFE_C_STRIG];
      SS_PIN: stg = edge_of(sif.pin[p], q.pp[p], q.mode[`WFE_M_TFALL]);
      SS_AIST: stg = edge_of(sif.ist, q.pist, q.mode[`WFE_M_TFALL]);
      default: stg = 1'b0;
    endcase
    fire = (q.mode[`WFE_M_TIM] != TIM_SW) &&
           ((cw[`WFE_C_START] && q.mode[`WFE_M_SSRC] == SS_CMD) || (q.st == ST_ARM && stg));
    if (cw[`WFE_C_START] && !fire && q.mode[`WFE_M_TIM] != TIM_SW) begin
      n.st = ST_ARM;
    end
    if (fire) begin
      n.st = (q.mode[`WFE_M_EXT] || q.mode[`WFE_M_CTR]) ? ST_RUN : ST_DLY;
      n.tbc = 24'h000000;
      n.done = 32'h00000000;
      n.err = 1'b0;
    end
    if (cw[`WFE_C_ECLR]) begin
      n.err = 1'b0;
      n.refused = 1'b0;
    end
    if (cw[`WFE_C_STOP]) begin
      n.st = ST_IDLE;
    end
    // Sample event; pause is sampled only at a sample boundary
    ev = ((q.st == ST_RUN || q.st == ST_DLY) && tick && !pause_act) ||
         (cw[`WFE_C_SWUPD] && q.mode[`WFE_M_TIM] == TIM_SW && q.st == ST_IDLE);
    regen = (q.mode[`WFE_M_RGN] != RGN_NONE) && (q.mode[`WFE_M_TIM] != TIM_SW);
    pop = 1'b0;
    rot = 1'b0;
    if (ev) begin
      if (q.lvl == 7'h00) begin
        n.err = 1'b1;
        n.st = ST_IDLE;
      end else begin
        n.dac0 = rd_word[15:0];
        n.dac1 = rd_word[31:16];
        n.upd = 1'b1;
        n.rd = q.rd + 6'h01;
        pop = ~regen;
        rot = regen;
        n.done = q.done + 32'h00000001;
        if (q.mode[`WFE_M_TIM] == TIM_FIN && q.st != ST_IDLE && q.done + 32'h00000001 >= q.cnt) begin
          n.st = ST_IDLE;
        end
      end
    end
    // Replay recirculates the sample; host push waits a cycle
    push = q.pend & ~rot;
    mwe = rot | push;
    mwd = rot ? rd_word : q.pend_d;
    if (mwe) begin
      n.wr = q.wr + 6'h01;
    end
    if (push) begin
      n.pend = 1'b0;
    end
    n.lvl = q.lvl + {6'h00, push} - {6'h00, pop};
    // Write channel
    if (q.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid_i && q.awready) begin
      n.aw_ok = 1'b1;
      n.waddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      n.w_ok = 1'b1;
      n.wdata = s_axi_wdata_i;
      n.wstrb = s_axi_wstrb_i;
    end
    if (wcommit) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = 2'b00;
      case (q.waddr)
        `WFE_A_CTRL: n.bresp = 2'b00;
        `WFE_A_MODE: begin
          mw = merge({18'h00000, q.mode}, q.wdata, q.wstrb);
          n.mode = mw[13:0];
        end
        `WFE_A_PINS: begin
          mw = merge({12'h000, q.pins}, q.wdata, q.wstrb);
          n.pins = mw[19:0];
        end
        `WFE_A_DIV: begin
          mw = merge({8'h00, q.div}, q.wdata, q.wstrb);
          n.div = mw[23:0];
        end
        `WFE_A_DLY: begin
          mw = merge({16'h0000, q.dly}, q.wdata, q.wstrb);
          n.dly = mw[15:0];
        end
        `WFE_A_CNT: n.cnt = merge(q.cnt, q.wdata, q.wstrb);
        `WFE_A_DATA: begin
          if (q.lvl == `WFE_DEPTH || (q.mode[`WFE_M_RGN] == RGN_FIFO && q.st != ST_IDLE)) begin
            n.bresp = 2'b10;
            n.refused = 1'b1;
          end else begin
            n.pend = 1'b1;
            n.pend_d = q.wdata;
          end
        end
        default: n.bresp = 2'b10;
      endcase
    end
    n.awready = ~n.aw_ok;
    n.wready = ~n.w_ok;
    // Read channel
    if (q.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = 2'b00;
      case (s_axi_araddr_i)
        `WFE_A_CTRL: n.rdata = 32'h00000000;
        `WFE_A_MODE: n.rdata = {18'h00000, q.mode};
        `WFE_A_PINS: n.rdata = {12'h000, q.pins};
        `WFE_A_DIV: n.rdata = {8'h00, q.div};
        `WFE_A_DLY: n.rdata = {16'h0000, q.dly};
        `WFE_A_CNT: n.rdata = q.cnt;
        `WFE_A_DATA: n.rdata = 32'h00000000;
        `WFE_A_STAT: n.rdata = {14'h0000, q.st, 1'b0, q.lvl, 2'b00, q.refused, pause_act,
                                q.err, q.lvl == `WFE_DEPTH, q.lvl == 7'h00, q.st == ST_RUN};
        `WFE_A_DONE: n.rdata = q.done;
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = 2'b10;
        end
      endcase
    end
    n.arready = ~n.rvalid;
    // Pin exports; start pulse has priority on a shared pin
    n.fpo = 16'h0000;
    n.fpoe = 16'h0000;
    if (q.pins[`WFE_P_XSCE]) begin
      p = pin_out(q.pins[`WFE_P_XSC]);
      n.fpoe[p] = 1'b1;
      n.fpo[p] = ~n.upd;
    end
    if (q.pins[`WFE_P_XSTE]) begin
      p = pin_out(q.pins[`WFE_P_XST]);
      n.fpoe[p] = 1'b1;
      n.fpo[p] = fire;
    end
  end

  // ----------------------------------------
  // State register and sample memory
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.mode <= `WFE_R_MODE;
      q.pins <= `WFE_R_PINS;
      q.div <= `WFE_R_DIV;
      q.dly <= `WFE_R_DLY;
      q.cnt <= `WFE_R_CNT;
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mwe) begin
      mem[q.wr] <= mwd;
    end
  end

  assign fpin_o = q.fpo;
  assign fpin_oe_o = q.fpoe;
  assign dac0_o = q.dac0;
  assign dac1_o = q.dac1;
  assign dac_upd_o = q.upd;
  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign s_axi_rvalid_o = q.rvalid;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_dac_together;
    (dac0_o != $past(dac0_o) || dac1_o != $past(dac1_o)) |-> dac_upd_o;
  endproperty
  a_dac_together: assert property (p_dac_together) else $error("converter changed without update");

  property p_pause_mask;
    (pause_act && q.st == ST_RUN) |=> !dac_upd_o;
  endproperty
  a_pause_mask: assert property (p_pause_mask) else $error("update while paused");

  property p_sw_one;
    (ev && q.lvl != 7'h00 && q.mode[`WFE_M_TIM] == TIM_SW) |=> dac_upd_o ##1 !dac_upd_o;
  endproperty
  a_sw_one: assert property (p_sw_one) else $error("software update count wrong");

  property p_finite_stop;
    (q.st == ST_RUN && q.mode[`WFE_M_TIM] == TIM_FIN && q.cnt != 32'h00000000) |-> q.done < q.cnt;
  endproperty
  a_finite_stop: assert property (p_finite_stop) else $error("finite run past count");

  property p_underflow;
    (ev && q.lvl == 7'h00) |=> (q.err && q.st == ST_IDLE && !dac_upd_o);
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not reported");

  property p_err_sticky;
    (q.err && !cw[`WFE_C_ECLR] && !fire) |=> q.err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

  property p_idle_quiet;
    (q.st == ST_IDLE && q.mode[`WFE_M_TIM] != TIM_SW) |=> !dac_upd_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("update while idle");

  property p_start_export;
    (fire && q.pins[`WFE_P_XSTE]) |=> fpin_o[pin_out($past(q.pins[`WFE_P_XST]))];
  endproperty
  a_start_export: assert property (p_start_export) else $error("start export pulse missing");

  property p_sclk_export;
    (dac_upd_o && $past(q.pins[`WFE_P_XSCE]) && !$past(fire && q.pins[`WFE_P_XSTE]))
      |-> !fpin_o[pin_out($past(q.pins[`WFE_P_XSC]))];
  endproperty
  a_sclk_export: assert property (p_sclk_export) else $error("sample clock export not low");
endmodule

/* File: tb/wfe_pin_model.sv */
/*
  Far-side pin model: trigger, pause and sample clock levels on the input pins.
  Assumes the bench clock; output-only pins read low through their pull-downs.
*/
`timescale 1ns/1ps
module wfe_pin_model (
  input wire logic clk_i,
  input wire logic sclk_en_i,
  input wire logic trig_i,
  input wire logic pause_i,
  output logic [15:0] fpin_o,
  output logic in_start_o,
  output logic ctr_o
);
  logic [2:0] div_r = 3'h0;
  logic tick;
  // ----------------------------------------
  // Slow clock, stands still when disabled
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    div_r <= div_r + 3'h1;
  end
  assign tick = sclk_en_i & div_r[2];
  assign fpin_o = {13'h0, pause_i, trig_i, tick};
  assign in_start_o = trig_i;
  assign ctr_o = tick;
endmodule

/* File: tb/waveform_output_timing_engine_test.sv */
/*
  Self-checking bench of the waveform output timing engine.
  Assumes the engine's register map and the pin model beside it.
*/
`timescale 1ns/1ps
`include "wfe_regs.svh"
module waveform_output_timing_engine_test;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, r_d, r, w;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic aw_r, w_r, b_v, ar_r, r_v, upd, ist, ctr, xsc = 1'b0;
  logic sen = 1'b0, trig = 1'b0, pse = 1'b0;
  logic [1:0] b_s, r_s, rs;
  logic [15:0] fpin, fo, foe, d0, d1;
  logic [31:0] seen[$], wq[$];
  int err_count = 0, n_checks = 0, n_st = 0, i, s, n0, n1;

  wfe_pin_model u_pins (.clk_i(clk_i), .sclk_en_i(sen), .trig_i(trig), .pause_i(pse),
    .fpin_o(fpin), .in_start_o(ist), .ctr_o(ctr));
  wfe_engine u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fpin_i(fpin), .in_start_i(ist),
    .ctr_out_i(ctr), .fpin_o(fo), .fpin_oe_o(foe), .dac0_o(d0), .dac1_o(d1), .dac_upd_o(upd),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r), .s_axi_wdata_i(w_d),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r), .s_axi_bresp_o(b_s),
    .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
    .s_axi_arready_o(ar_r), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_s), .s_axi_rvalid_o(r_v),
    .s_axi_rready_i(r_r));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 400) begin
      err_count++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge clk_i);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_i);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      if (b_v === 1'b1) break;
    end
    tmo(n);
    b_r <= 1'b0;
    chk(32'(b_s), 32'(e));
  endtask

  task automatic rdw(input logic [7:0] a);
    int n;
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_i);
      if (ar_r) ar_v <= 1'b0;
      if (r_v === 1'b1) break;
    end
    tmo(n);
    r_r <= 1'b0;
    r = r_d;
    rs = r_s;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdw(a);
    chk(r & m, e);
    chk(32'(rs), 32'h0);
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 400; n++) begin
      rdw(`WFE_A_STAT);
      if ((r & m) === v) break;
    end
    tmo(n);
  endtask

  task automatic push(input int k);
    repeat (k) begin
      w = $urandom();
      wq.push_back(w);
      wr(`WFE_A_DATA, w, 2'b00);
    end
  endtask

  task automatic rst;
    xsc <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    seen.delete();
    wq.delete();
    rdc(`WFE_A_STAT, 32'h0003FFFF, 32'h00000002);
    rdc(`WFE_A_DLY, 32'h0000FFFF, 32'h00000002);
    wr(`WFE_A_PINS, 32'h00089011, 2'b00);
    xsc <= 1'b1;
  endtask

  function automatic logic [31:0] rep(input int k);
    return wq[k % wq.size()];
  endfunction

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (upd === 1'b1) seen.push_back({d1, d0});
    if (fo[5] === 1'b1) n_st++;
    if (xsc) chk(32'({foe[4], fo[4]}), 32'({1'b1, ~upd}));
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n0 = $urandom(32'hE826);
    rst();
    rdw(8'h40);
    chk(r, 32'h0);
    chk(32'(rs), 32'h2);
    wr(`WFE_A_MODE, 32'h00000008, 2'b00);
    push(3);
    rdc(`WFE_A_STAT, 32'h00007F00, 32'h00000300);
    for (i = 0; i < 3; i++) begin
      wr(`WFE_A_CTRL, 32'h00000004, 2'b00);
      repeat (4) @(posedge clk_i);
      chk(32'(seen.size()), 32'(i + 1));
      chk(seen[i], wq[i]);
    end
    seen.delete();
    wq.delete();
    wr(`WFE_A_MODE, 32'h00000001, 2'b00);
    wr(`WFE_A_DIV, 32'h00000004, 2'b00);
    wr(`WFE_A_CNT, 32'h00000005, 2'b00);
    push(2);
    wr(`WFE_A_CTRL, 32'h00000001, 2'b00);
    poll(32'h00030000, 32'h00030000);
    poll(32'h00030001, 32'h0);
    repeat (40) @(posedge clk_i);
    chk(32'(seen.size()), 32'h5);
    for (i = 0; i < 5; i++) chk(seen[i], rep(i));
    rdc(`WFE_A_DONE, 32'hFFFFFFFF, 32'h00000005);
    wr(`WFE_A_CNT, 32'h00000001, 2'b00);
    for (s = 1; s < 4; s++) begin
      n0 = seen.size();
      trig <= (s == 2);
      wr(`WFE_A_MODE, {20'h0, s == 2, s[1:0], 9'h001}, 2'b00);
      wr(`WFE_A_CTRL, 32'h00000001, 2'b00);
      repeat (10) @(posedge clk_i);
      rdc(`WFE_A_STAT, 32'h00030000, 32'h00010000);
      chk(32'(seen.size()), 32'(n0));
      n1 = n_st;
      if (s == 1) wr(`WFE_A_CTRL, 32'h00000010, 2'b00);
      else trig <= (s == 3);
      poll(32'h00030000, 32'h0);
      repeat (10) @(posedge clk_i);
      chk(32'(seen.size()), 32'(n0 + 1));
      chk(32'(n_st - n1), 32'h1);
    end
    wr(`WFE_A_MODE, 32'h00000042, 2'b00);
    n0 = seen.size();
    sen <= 1'b1;
    wr(`WFE_A_CTRL, 32'h00000001, 2'b00);
    repeat (40) @(posedge clk_i);
    wr(`WFE_A_DATA, $urandom(), 2'b00);
    repeat (40) @(posedge clk_i);
    rdc(`WFE_A_STAT, 32'h00000001, 32'h00000001);
    chk(32'(seen.size() > n0 + 4), 32'h1);
    wr(`WFE_A_CTRL, 32'h00000002, 2'b00);
    poll(32'h00000001, 32'h0);
    n0 = seen.size();
    repeat (40) @(posedge clk_i);
    chk(32'(seen.size()), 32'(n0));
    wr(`WFE_A_MODE, 32'h00000006, 2'b00);
    wr(`WFE_A_CTRL, 32'h00000001, 2'b00);
    wr(`WFE_A_DATA, 32'h12345678, 2'b10);
    rdc(`WFE_A_STAT, 32'h00000020, 32'h00000020);
    wr(`WFE_A_CTRL, 32'h0000000A, 2'b00);
    poll(32'h00000021, 32'h0);
    rdw(`WFE_A_STAT);
    for (i = r[14:8]; i < 64; i++) wr(`WFE_A_DATA, $urandom(), 2'b00);
    rdc(`WFE_A_STAT, 32'h00007F04, 32'h00004004);
    wr(`WFE_A_DATA, 32'h0, 2'b10);
    rst();
    wr(`WFE_A_MODE, 32'h0000101A, 2'b00);
    push(4);
    pse <= 1'b1;
    wr(`WFE_A_CTRL, 32'h00000001, 2'b00);
    repeat (60) @(posedge clk_i);
    chk(32'(seen.size()), 32'h0);
    pse <= 1'b0;
    poll(32'h00000008, 32'h00000008);
    rdc(`WFE_A_STAT, 32'h00030001, 32'h0);
    chk(32'(seen.size()), 32'h4);
    for (i = 0; i < 4; i++) chk(seen[i], wq[i]);
    repeat (40) @(posedge clk_i);
    chk(32'(seen.size()), 32'h4);
    wr(`WFE_A_CTRL, 32'h00000008, 2'b00);
    rdc(`WFE_A_STAT, 32'h00000008, 32'h0);
    summarize();
  end
endmodule
